/* design/acrc_ctrl.v */
// convert and read control of the 12-bit converter
`timescale 1ns/1ps
`include "acrc_defines.vh"
module acrc_ctrl (
	input wire ref_clk_i,
	input wire reset_i,
	input wire read_not_convert_i,
	input wire select_n_i,
	input wire conv_gate_i,
	input wire nibble_select_i,
	input wire compare_i,
	output reg status_o,
	output reg [`ACRC_BUS_W-1:0] data_o,
	output wire [`ACRC_BUS_W-1:0] data_oe_o
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_CONV = 3'b010;
	localparam [2:0] ST_HOLD = 3'b100;
	// synchroniser bank order: read line, select, gate, nibble select
	localparam PIN_N = 4;
	localparam PIN_RNC = 0;
	localparam PIN_SEL = 1;
	localparam PIN_GATE = 2;
	localparam PIN_NIB = 3;
	// idle pin levels, so reset leaves no false start edge
	localparam [3:0] PIN_IDLE = 4'b0011;

	reg [2:0] state;
	reg [2:0] next_state;
	reg next_status;
	reg start_cond_d;
	reg [`ACRC_RESULT_W-1:0] result;
	reg [`ACRC_RESULT_W-1:0] next_result;
	reg [`ACRC_CNT_W-1:0] hold_cnt;
	reg [`ACRC_CNT_W-1:0] next_hold_cnt;
	reg drive_en;
	reg [`ACRC_BUS_W-1:0] next_data;
	wire [PIN_N-1:0] pin_raw;
	wire [PIN_N-1:0] pin_sync;
	wire rnc_sync;
	wire sel_n_sync;
	wire gate_sync;
	wire nib_sync;
	wire [`ACRC_RESULT_W-1:0] sar_value;
	wire sar_done;
	wire start_cond;
	wire start_pulse;
	wire hold_last;
	wire read_cond;
	genvar gp;
	genvar gb;

	assign pin_raw[PIN_RNC] = read_not_convert_i;
	assign pin_raw[PIN_SEL] = select_n_i;
	assign pin_raw[PIN_GATE] = conv_gate_i;
	assign pin_raw[PIN_NIB] = nibble_select_i;

	// two-stage synchronisers; only stage one feeds stage two
	generate
		for (gp = 0; gp < PIN_N; gp = gp + 1) begin : g_sync
			reg meta;
			reg stable;
			always @(posedge ref_clk_i) begin
				if (reset_i) begin
					meta <= PIN_IDLE[gp];
					stable <= PIN_IDLE[gp];
				end else begin
					meta <= pin_raw[gp];
					stable <= meta;
				end
			end
			assign pin_sync[gp] = stable;
		end
	endgenerate

	assign rnc_sync = pin_sync[PIN_RNC];
	assign sel_n_sync = pin_sync[PIN_SEL];
	assign gate_sync = pin_sync[PIN_GATE];
	assign nib_sync = pin_sync[PIN_NIB];

	assign start_cond = !rnc_sync && !sel_n_sync && gate_sync;
	// same path for all three inputs
	assign start_pulse = start_cond && !start_cond_d && state == ST_IDLE;
	// last hold cycle before status falls
	assign hold_last = hold_cnt == `ACRC_LATCH_LEAD_CYC - 1;

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_pulse)
					next_state = ST_CONV;
			end
			ST_CONV: begin
				if (sar_done)
					next_state = ST_HOLD;
			end
			ST_HOLD: begin
				if (hold_last)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// raised within a few cycles of start edge
	always @* begin
		next_status = status_o;
		if (start_pulse)
			next_status = 1'b1;
		else if (state == ST_HOLD && hold_last)
			next_status = 1'b0;
	end

	// latch result, then wait before status falls
	always @* begin
		next_result = result;
		if (sar_done)
			next_result = sar_value;
	end

	always @* begin
		if (state == ST_HOLD)
			next_hold_cnt = hold_cnt + 11'h001;
		else
			next_hold_cnt = 11'h000;
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			start_cond_d <= 1'b0;
			status_o <= 1'b0;
			result <= 12'h000;
			hold_cnt <= 11'h000;
		end else begin
			state <= next_state;
			start_cond_d <= start_cond;
			status_o <= next_status;
			result <= next_result;
			hold_cnt <= next_hold_cnt;
		end
	end

	acrc_sar u_sar (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.start_i(start_pulse),
		.compare_i(compare_i),
		.approximation_register_o(sar_value),
		.done_o(sar_done)
	);

	assign read_cond = rnc_sync && !status_o && gate_sync && !sel_n_sync;

	// upper eight or lower four bits
	always @* begin
		if (nib_sync)
			next_data = {4'h0, result[3:0]};
		else
			next_data = result[11:4];
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			drive_en <= 1'b0;
			data_o <= 8'h00;
		end else begin
			drive_en <= read_cond;
			data_o <= next_data;
		end
	end

	// one enable per data line, all following the read condition
	generate
		for (gb = 0; gb < `ACRC_BUS_W; gb = gb + 1) begin : g_oe
			assign data_oe_o[gb] = drive_en;
		end
	endgenerate
endmodule

/* design/acrc_defines.vh */
// timing counts and widths for the converter control block
`ifndef ACRC_DEFINES_VH
`define ACRC_DEFINES_VH
`define ACRC_CLK_PERIOD_NS 8
`define ACRC_STATUS_DELAY_NS 200
`define ACRC_STATUS_DELAY_CYC ((`ACRC_STATUS_DELAY_NS) / (`ACRC_CLK_PERIOD_NS))
`define ACRC_LATCH_LEAD_NS 500
`define ACRC_LATCH_LEAD_CYC (((`ACRC_LATCH_LEAD_NS) + (`ACRC_CLK_PERIOD_NS) - 1) / (`ACRC_CLK_PERIOD_NS))
`define ACRC_CONV_MAX_NS 10000
`define ACRC_CONV_MAX_CYC ((`ACRC_CONV_MAX_NS) / (`ACRC_CLK_PERIOD_NS))
`define ACRC_BIT_CYC 8'h50
`define ACRC_RESULT_W 12
`define ACRC_BUS_W 8
`define ACRC_CNT_W 11
`endif

/* design/acrc_sar.v */
// successive-approximation sequencer for a 12-bit result
`timescale 1ns/1ps
`include "acrc_defines.vh"
module acrc_sar (
	input wire ref_clk_i,
	input wire reset_i,
	input wire start_i,
	input wire compare_i,
	output reg [`ACRC_RESULT_W-1:0] approximation_register_o,
	output reg done_o
);
	reg [`ACRC_RESULT_W-1:0] trial_bit;
	reg [7:0] bit_cnt;
	reg clk_run;

	always @(posedge ref_clk_i) begin
		done_o <= 1'b0;
		if (reset_i) begin
			approximation_register_o <= 12'h000;
			trial_bit <= 12'h000;
			bit_cnt <= 8'h00;
			clk_run <= 1'b0;
		end else if (start_i) begin
			approximation_register_o <= 12'h800;
			trial_bit <= 12'h800;
			bit_cnt <= 8'h00;
			clk_run <= 1'b1;
		end else if (clk_run) begin
			if (bit_cnt == `ACRC_BIT_CYC - 8'h01) begin
				bit_cnt <= 8'h00;
				// keep or drop the trial bit, then try the next one
				if (!compare_i)
					approximation_register_o <= (approximation_register_o & ~trial_bit)
						| (trial_bit >> 1);
				else
					approximation_register_o <= approximation_register_o | (trial_bit >> 1);
				trial_bit <= trial_bit >> 1;
				if (trial_bit == 12'h001) begin
					clk_run <= 1'b0;
					done_o <= 1'b1;
				end
			end else begin
				bit_cnt <= bit_cnt + 8'h01;
			end
		end
	end
endmodule

/* bench/acrc_check_assertions.sv */
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module acrc_check (
	input wire ref_clk_i,
	input wire reset_i,
	input wire read_not_convert_i,
	input wire select_n_i,
	input wire conv_gate_i,
	input wire nibble_select_i,
	input wire status_o,
	input wire [7:0] data_o,
	input wire [7:0] data_oe_o
);
	wire go = !read_not_convert_i && !select_n_i && conv_gate_i;
	wire rd = read_not_convert_i && !status_o && conv_gate_i && !select_n_i;
	reg [10:0] busy = 11'h0;
	always @(posedge ref_clk_i) busy <= status_o ? busy + 11'h1 : 11'h0;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	sequence go_s; !status_o && $rose(go) ##1 go; endsequence
	sequence rd_s; rd [*4]; endsequence
	float_convert_a: assert property (!read_not_convert_i [*4] |-> data_oe_o == 8'h00)
		else $error("driven in convert");
	status_rise_a: assert property (go_s |-> ##[0:23] status_o)
		else $error("status late");
	busy_hold_a: assert property ($rose(status_o) |-> status_o [*8])
		else $error("status short");
	busy_bound_a: assert property (busy < 11'h4e2)
		else $error("conversion long");
	read_drive_a: assert property (rd_s |-> data_oe_o == 8'hff)
		else $error("read not driven");
	drive_idle_a: assert property (data_oe_o != 8'h00 |-> !status_o && data_oe_o == 8'hff)
		else $error("driven when busy");
	float_gate_a: assert property ($fell(conv_gate_i) && data_oe_o[0] |->
		data_oe_o[0] [*2] ##[1:16] !data_oe_o[0]) else $error("float wrong");
	nibble_low_a: assert property ((nibble_select_i && data_oe_o[0]) [*4] |-> data_o[7:4] == 4'h0)
		else $error("upper not zero");
endmodule

/* bench/acrc_comp_model.sv */
// comparator model: answers one code msb first, one bit per slot
`timescale 1ns/1ps
module acrc_comp_model (
	input wire ref_clk_i,
	input wire busy_i,
	input wire [11:0] code_i,
	output wire compare_o
);
	reg [10:0] cnt = 11'h0;
	wire [10:0] idx = (cnt + 11'h28) / 11'h50;
	always @(posedge ref_clk_i) cnt <= busy_i ? cnt + 11'h1 : 11'h0;
	assign compare_o = (idx > 0 && idx < 13) ? code_i[12 - idx] : cnt[0];
endmodule

/* bench/acrc_ctrl_tb.sv */
// self-checking bench for the convert and read control
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("ERROR %0t %h %h", $time, a, b); end end
module acrc_ctrl_tb;
	logic clk, rst = 1'b1, rnc = 1'b1, sel_n = 1'b1, gate = 1'b0, nib = 1'b0, cmp, busy;
	logic [7:0] dat, oe;
	logic [11:0] code = 12'h000;
	int checks = 0, miscompares = 0;
	acrc_ctrl DUT (.ref_clk_i(clk), .reset_i(rst), .read_not_convert_i(rnc), .select_n_i(sel_n),
		.conv_gate_i(gate), .nibble_select_i(nib), .compare_i(cmp), .status_o(busy),
		.data_o(dat), .data_oe_o(oe));
	acrc_comp_model CMP (.ref_clk_i(clk), .busy_i(busy), .code_i(code), .compare_o(cmp));
	task give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// which: 0 read line, 1 gate, 2 select is the last start edge
	task automatic convert(input int which, input logic [11:0] c);
		code <= c;
		rnc <= which == 0;
		sel_n <= which == 2;
		gate <= which != 1;
		repeat (8) @(posedge clk);
		rnc <= 1'b0;
		sel_n <= 1'b0;
		gate <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(busy, 1'b1)
		`CHK(oe, 8'h00)
		gate <= 1'b0;
		repeat (4) @(posedge clk);
		gate <= 1'b1;
		repeat (892) @(posedge clk);
		`CHK(busy, 1'b1)
		repeat (340) @(posedge clk);
		`CHK(busy, 1'b0)
		rnc <= 1'b1;
		repeat (19) @(posedge clk);
		`CHK(oe, 8'hff)
		`CHK(dat, c[11:4])
		nib <= 1'b1;
		repeat (7) @(posedge clk);
		`CHK(dat, {4'h0, c[3:0]})
		gate <= 1'b0;
		nib <= 1'b0;
		repeat (19) @(posedge clk);
		`CHK(oe, 8'h00)
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (8000) @(posedge clk);
		miscompares++;
		give_verdict;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		convert(0, 12'ha5c);
		convert(1, 12'hfff);
		convert(2, 12'h000);
		give_verdict;
	end
endmodule
bind acrc_ctrl acrc_check chk (.ref_clk_i, .reset_i, .read_not_convert_i, .select_n_i,
	.conv_gate_i, .nibble_select_i, .status_o, .data_o, .data_oe_o);
